// File: logic/cmdt_top.sv
// Local design decisions: the placing of the registers and strobed register access.
`include "cmdt_consts.svh"
module cmdt_top import cmdt_pkg::*; #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [`CMDT_ADDR_W-1:0] addr,
  input wire logic [`CMDT_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`CMDT_DATA_W-1:0] rdata,
  // DMA controller side
  output logic dma_req,
  // Processor interrupt, usage faults only
  output logic irq
);
  if (CNT_W < 2 || CNT_W > `CMDT_DATA_W) begin : g_bad_cnt
    $error("cmdt_top: CNT_W must lie between 2 and the data width");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic start;
    logic dreq_en;
    cmdt_cks_t cks;
    logic flag;
    logic armed;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    cmdt_ev_t ist;
    cmdt_ev_t imask;
    logic match;
    logic [`CMDT_DATA_W-1:0] rdata;
    logic dma_req;
    logic irq;
  } cmdt_st_t;

  cmdt_st_t s_q, s_d;

  function automatic logic hit(input logic [`CMDT_ADDR_W-1:0] a,
                               input logic [`CMDT_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic wr_start;
  logic wr_csr;
  logic wr_cnt;
  logic wr_cor;
  logic wr_ist;
  logic wr_imsk;
  logic rd_csr;
  logic [CNT_W-1:0] wnum;
  cmdt_ev_t ev;

  assign wr_start = wr && hit(addr, `CMDT_OFF_START);
  assign wr_csr = wr && hit(addr, `CMDT_OFF_CSR);
  assign wr_cnt = wr && hit(addr, `CMDT_OFF_CNT);
  assign wr_cor = wr && hit(addr, `CMDT_OFF_COR);
  assign wr_ist = wr && hit(addr, `CMDT_OFF_IST);
  assign wr_imsk = wr && hit(addr, `CMDT_OFF_IMSK);
  assign rd_csr = rd && hit(addr, `CMDT_OFF_CSR);
  assign wnum = wdata[CNT_W-1:0];

  // Counter and period writes during counting are not synchronised to the count, so flag them
  assign ev[`CMDT_EV_WRUN] = s_q.start && (wr_cnt || wr_cor);
  // New period below the count makes the counter run round its full range
  assign ev[`CMDT_EV_BEHIND] = s_q.start && wr_cor && (wnum < s_q.cnt);

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  cmdt_if u_if ();

  assign u_if.sel = s_q.cks;
  assign u_if.run = s_q.start;

  cmdt_prescaler #(
    .PRE_W(`CMDT_PRE_W)
  ) u_pre (
    .clk(clk),
    .reset(reset),
    .pif(u_if.pre)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.match = 1'b0;
    s_d.dma_req = 1'b0;
    s_d.rdata = '0;

    // Counting; match only on the tick that wraps to zero
    if (s_q.start && u_if.tick) begin // (R3) (R13)
      if (s_q.cnt == s_q.period) begin // (R9)
        s_d.cnt = '0; // (R5)
        s_d.match = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1); // (R4)
      end
    end
    // Software write wins over a tick in the same cycle
    if (wr_cnt) begin
      s_d.cnt = wnum;
    end
    if (wr_cor) begin
      s_d.period = wnum; // (R7)
    end

    if (wr_start) begin
      s_d.start = wdata[`CMDT_BIT_STR]; // (R13)
    end

    // Control and flag; reserved bits are not stored
    if (wr_csr) begin
      s_d.dreq_en = wdata[`CMDT_BIT_DREQ];
      s_d.cks = {wdata[`CMDT_CKS_HI], wdata[`CMDT_CKS_LO]}; // (R2)
      if (!wdata[`CMDT_BIT_FLAG] && s_q.armed) begin // (R10) (R12)
        s_d.flag = 1'b0;
      end
      s_d.armed = 1'b0;
    end
    if (rd_csr && s_q.flag) begin // (R12)
      s_d.armed = 1'b1;
    end
    // Setting wins over a clear in the same cycle
    if (s_d.match) begin // (R5)
      s_d.flag = 1'b1;
    end

    // Request goes only to the DMA controller
    s_d.dma_req = s_d.match && s_q.dreq_en; // (R1) (R14) (R15)

    // Usage fault events, write one to clear, set wins
    if (wr_ist) begin
      s_d.ist = s_q.ist & ~wdata[`CMDT_EV_W-1:0];
    end
    s_d.ist = s_d.ist | ev;
    if (wr_imsk) begin
      s_d.imask = wdata[`CMDT_EV_W-1:0];
    end
    s_d.irq = |(s_d.ist & s_d.imask); // (R14)

    // Read data, one cycle after the strobe; unmapped reads zero
    if (rd) begin
      if (hit(addr, `CMDT_OFF_START)) begin
        s_d.rdata[`CMDT_BIT_STR] = s_q.start;
      end else if (hit(addr, `CMDT_OFF_CSR)) begin
        s_d.rdata[`CMDT_BIT_FLAG] = s_q.flag; // (R11)
        s_d.rdata[`CMDT_BIT_DREQ] = s_q.dreq_en;
        s_d.rdata[`CMDT_CKS_HI] = s_q.cks[1];
        s_d.rdata[`CMDT_CKS_LO] = s_q.cks[0];
      end else if (hit(addr, `CMDT_OFF_CNT)) begin
        s_d.rdata = `CMDT_DATA_W'(s_q.cnt); // (R4)
      end else if (hit(addr, `CMDT_OFF_COR)) begin
        s_d.rdata = `CMDT_DATA_W'(s_q.period);
      end else if (hit(addr, `CMDT_OFF_IST)) begin
        s_d.rdata = `CMDT_DATA_W'(s_q.ist);
      end else if (hit(addr, `CMDT_OFF_IMSK)) begin
        s_d.rdata = `CMDT_DATA_W'(s_q.imask);
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.cnt <= CNT_W'(`CMDT_CNT_RST); // (R6)
      s_q.period <= CNT_W'(`CMDT_COR_RST); // (R8)
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign dma_req = s_q.dma_req;
  assign irq = s_q.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_req_needs_en;
    @(posedge clk) disable iff (reset)
    s_q.dma_req |-> $past(s_q.dreq_en) && s_q.match;
  endproperty
  a_req_needs_en: assert property (p_req_needs_en) // (R1)
    else $error("DMA request without enable");

  property p_req_on_match;
    @(posedge clk) disable iff (reset)
    s_q.match && $past(s_q.dreq_en) |-> s_q.dma_req ##1 !s_q.dma_req;
  endproperty
  a_req_on_match: assert property (p_req_on_match) // (R15)
    else $error("DMA request not a single pulse per match");

  property p_count_step;
    @(posedge clk) disable iff (reset)
    $past(s_q.start && u_if.tick && s_q.cnt != s_q.period && !wr_cnt)
    |-> s_q.cnt == CNT_W'($past(s_q.cnt) + CNT_W'(1));
  endproperty
  a_count_step: assert property (p_count_step) // (R3)
    else $error("counter did not step by one on tick");

  property p_halt;
    @(posedge clk) disable iff (reset)
    $past(!s_q.start && !wr_cnt) |-> $stable(s_q.cnt);
  endproperty
  a_halt: assert property (p_halt) // (R13)
    else $error("counter moved while halted");

  property p_wrap;
    @(posedge clk) disable iff (reset)
    s_q.match && !$past(wr_cnt) |-> s_q.cnt == '0 && s_q.flag;
  endproperty
  a_wrap: assert property (p_wrap) // (R5)
    else $error("match without wrap to zero and flag");

  property p_match_late;
    @(posedge clk) disable iff (reset)
    s_q.match |-> $past(s_q.cnt == s_q.period && u_if.tick && s_q.start);
  endproperty
  a_match_late: assert property (p_match_late) // (R9)
    else $error("match not on the tick after equality");

  property p_flag_rise;
    @(posedge clk) disable iff (reset)
    $rose(s_q.flag) |-> s_q.match;
  endproperty
  a_flag_rise: assert property (p_flag_rise) // (R10)
    else $error("flag set by software");

  property p_flag_clear;
    @(posedge clk) disable iff (reset)
    $fell(s_q.flag) |-> $past(wr_csr && !wdata[`CMDT_BIT_FLAG] && s_q.armed);
  endproperty
  a_flag_clear: assert property (p_flag_clear) // (R12)
    else $error("flag cleared without prior read of one");

  property p_reserved;
    @(posedge clk) disable iff (reset)
    $past(rd_csr) |-> s_q.rdata[6:5] == 2'h0 && s_q.rdata[3:2] == 2'h0
                      && s_q.rdata[15:8] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) // (R11)
    else $error("reserved status bits not zero");

  property p_reset_vals;
    @(posedge clk) disable iff (reset)
    $past(reset) |-> s_q.cnt == '0 && s_q.period == '1 && !s_q.start;
  endproperty
  a_reset_vals: assert property (p_reset_vals) // (R6)
    else $error("wrong values after reset");

  property p_no_match_irq;
    @(posedge clk) disable iff (reset)
    $rose(s_q.irq) |-> $past(ev != '0 || wr_imsk);
  endproperty
  a_no_match_irq: assert property (p_no_match_irq) // (R14)
    else $error("interrupt raised without a usage fault");

  property p_period_reset;
    @(posedge clk) disable iff (reset)
    $past(reset) |=> s_q.period == '1 || $past(wr_cor);
  endproperty
  a_period_reset: assert property (p_period_reset) // (R8)
    else $error("period not all ones after reset");

  // ----------------------------------------
  // Register write and link checks
  // ----------------------------------------
  // Read data must not linger, the bus has no select to qualify it
  property p_rdata_idle;
    @(posedge clk) disable iff (reset)
    !$past(rd) |-> s_q.rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  // Ticks are at least four clocks apart, so requests are too
  property p_req_gap;
    @(posedge clk) disable iff (reset)
    s_q.dma_req |=> !s_q.dma_req [*3];
  endproperty
  a_req_gap: assert property (p_req_gap) // (R15)
    else $error("DMA requests closer than four clocks");

  property p_armed_drop;
    @(posedge clk) disable iff (reset)
    $past(wr_csr) |-> !s_q.armed;
  endproperty
  a_armed_drop: assert property (p_armed_drop) // (R12)
    else $error("clear stayed armed after a control write");

  property p_arm_on_read;
    @(posedge clk) disable iff (reset)
    $past(rd_csr && s_q.flag) |-> s_q.armed;
  endproperty
  a_arm_on_read: assert property (p_arm_on_read) // (R12)
    else $error("read of a set flag did not arm the clear");

  property p_cnt_load;
    @(posedge clk) disable iff (reset)
    $past(wr_cnt) |-> s_q.cnt == $past(wnum);
  endproperty
  a_cnt_load: assert property (p_cnt_load) // (R4)
    else $error("counter not loaded by a write");

  property p_cor_load;
    @(posedge clk) disable iff (reset)
    $past(wr_cor) |-> s_q.period == $past(wnum);
  endproperty
  a_cor_load: assert property (p_cor_load) // (R7)
    else $error("period not loaded by a write");

  property p_start_load;
    @(posedge clk) disable iff (reset)
    $past(wr_start) |-> s_q.start == $past(wdata[`CMDT_BIT_STR]);
  endproperty
  a_start_load: assert property (p_start_load) // (R13)
    else $error("count start not loaded by a write");

  property p_ctl_load;
    @(posedge clk) disable iff (reset)
    $past(wr_csr) |-> s_q.dreq_en == $past(wdata[`CMDT_BIT_DREQ])
                      && s_q.cks == $past({wdata[`CMDT_CKS_HI], wdata[`CMDT_CKS_LO]});
  endproperty
  a_ctl_load: assert property (p_ctl_load) // (R2)
    else $error("control fields not loaded by a write");

  property p_flag_hold;
    @(posedge clk) disable iff (reset)
    s_q.flag && !(wr_csr && !wdata[`CMDT_BIT_FLAG] && s_q.armed) |=> s_q.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // (R10)
    else $error("flag dropped without an armed clear");
endmodule : cmdt_top

// File: inc/cmdt_consts.svh
`ifndef CMDT_CONSTS_SVH
`define CMDT_CONSTS_SVH
// Overview of operation
// (R1) Compare match raises a DMA request only while request enable bit 4 is 1.
// (R2) Clock select 00/01/10/11 divides the peripheral clock by 4/8/16/64.
// (R3) With count start set, the counter advances once per divided tick.
// (R4) Match counter is a 16-bit up-counter readable by software.
// (R5) On equality the counter wraps to zero, sets the flag, keeps counting.
// (R6) Reset loads the match counter with zero.
// (R7) A writable 16-bit period constant sets the compare match period.
// (R8) Reset loads the period constant with all ones.
// (R9) Match signal fires on the next tick after equality, as counter hits zero.
// (R10) Software can only clear the match flag with a 0; writing 1 does nothing.
// (R11) Reserved status bits 6, 5, 3, 2 read as zero; software writes zero.
// (R12) Flag clears only on a 0 write after reading the flag as 1.
// (R13) Count start bit 0 halts counting at 0, counts at 1, resets to 0.
// (R14) Compare match never raises a processor interrupt, only DMA requests.
// (R15) One DMA request pulse, one clock long, per match while enabled.
`define CMDT_ADDR_W 8
`define CMDT_DATA_W 16
`define CMDT_OFF_START 8'h00
`define CMDT_OFF_CSR 8'h04
`define CMDT_OFF_CNT 8'h08
`define CMDT_OFF_COR 8'h0c
`define CMDT_OFF_IST 8'h10
`define CMDT_OFF_IMSK 8'h14
`define CMDT_BIT_STR 0
`define CMDT_BIT_FLAG 7
`define CMDT_BIT_DREQ 4
`define CMDT_CKS_HI 1
`define CMDT_CKS_LO 0
`define CMDT_CNT_RST 16'h0000
`define CMDT_COR_RST 16'hffff
`define CMDT_CKS_DIV4 2'h0
`define CMDT_CKS_DIV8 2'h1
`define CMDT_CKS_DIV16 2'h2
`define CMDT_DIV4_LAST 6'h03
`define CMDT_DIV8_LAST 6'h07
`define CMDT_DIV16_LAST 6'h0f
`define CMDT_DIV64_LAST 6'h3f
`define CMDT_PRE_W 6
`define CMDT_EV_WRUN 0
`define CMDT_EV_BEHIND 1
`define CMDT_EV_W 2
`endif

// File: inc/cmdt_pkg.sv
package cmdt_pkg;
  typedef logic [1:0] cmdt_cks_t;
  typedef logic [1:0] cmdt_ev_t;
endpackage : cmdt_pkg

// File: inc/cmdt_if.sv
interface cmdt_if;
  import cmdt_pkg::*;
  cmdt_cks_t sel;
  logic run;
  logic tick;
  modport ctl (output sel, output run, input tick);
  modport pre (input sel, input run, output tick);
endinterface : cmdt_if

// File: logic/cmdt_prescaler.sv
`include "cmdt_consts.svh"
module cmdt_prescaler import cmdt_pkg::*; #(
  parameter int PRE_W = `CMDT_PRE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Timer side
  cmdt_if.pre pif
);
  if (PRE_W < `CMDT_PRE_W) begin : g_bad_width
    $error("cmdt_prescaler: PRE_W too small for divide by 64");
  end

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
    logic tick;
  } cmdt_pre_st_t;

  cmdt_pre_st_t s_q, s_d;
  logic [PRE_W-1:0] lim;

  function automatic logic [PRE_W-1:0] div_last(input cmdt_cks_t sel);
    case (sel)
      `CMDT_CKS_DIV4: div_last = PRE_W'(`CMDT_DIV4_LAST);
      `CMDT_CKS_DIV8: div_last = PRE_W'(`CMDT_DIV8_LAST);
      `CMDT_CKS_DIV16: div_last = PRE_W'(`CMDT_DIV16_LAST);
      default: div_last = PRE_W'(`CMDT_DIV64_LAST);
    endcase
  endfunction : div_last

  assign lim = div_last(pif.sel);

  // Divider restarts on stop so the first tick comes a full period late
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!pif.run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= lim) begin // (R2)
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + PRE_W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pif.tick = s_q.tick;

  property p_tick_at_limit;
    @(posedge clk) disable iff (reset)
    s_q.tick |-> $past(s_q.cnt) >= $past(lim) && s_q.cnt == '0;
  endproperty
  a_tick_at_limit: assert property (p_tick_at_limit) else $error("tick off divider limit"); // (R2)
endmodule : cmdt_prescaler

// File: tb/cmdt_dma_model.sv
module cmdt_dma_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Request from the timer
  input wire logic dma_req,
  // Requests taken so far
  output int unsigned seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Request intake
  // ----------------------------------------
  // Counts edges where the request is high; a stuck level would overcount
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seen <= 0;
    end else if (dma_req === 1'b1) begin
      seen <= seen + 1;
    end
  end
endmodule : cmdt_dma_sink

// File: tb/testbench.sv
`include "cmdt_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cmdt_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [`CMDT_ADDR_W-1:0] addr = 8'h00;
  logic [`CMDT_DATA_W-1:0] wdata = 16'h0000;
  logic [`CMDT_DATA_W-1:0] rdata;
  logic dma_req;
  logic irq;
  int unsigned seen;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int pulses = 0;
  int div [4] = '{4, 8, 16, 64};
  // ----------------------------------------
  // Clock, units under test
  // ----------------------------------------
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  cmdt_top #(.CNT_W(16)) cmdt_top_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .dma_req(dma_req), .irq(irq));
  cmdt_dma_sink cmdt_dma_sink_inst (.clk(clk), .reset(reset), .dma_req(dma_req), .seen(seen));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rchk
  task automatic wait_dma(output int t);
    t = 0;
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      #1;
      if (dma_req === 1'b1) begin
        t = cyc;
        pulses++;
        return;
      end
    end
    errors++;
    $display("BAD dma_req expected 1 seen 0");
  endtask : wait_dma
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    rchk(`CMDT_OFF_CNT, `CMDT_CNT_RST, "counter");
    rchk(`CMDT_OFF_COR, `CMDT_COR_RST, "period");
    rchk(`CMDT_OFF_START, 16'h0000, "start");
    rchk(8'h20, 16'h0000, "unmapped");
    // Reserved bits always written as zero, as software must
    wreg(`CMDT_OFF_CSR, 16'h0080);
    rchk(`CMDT_OFF_CSR, 16'h0000, "control");
    wreg(`CMDT_OFF_CNT, 16'h0005);
    rchk(`CMDT_OFF_CNT, 16'h0005, "counter");
    $display("test reset done");
  endtask : test_reset
  // Period 1 means two ticks per match
  task automatic test_dividers;
    int t0;
    int t1;
    for (int s = 0; s < 4; s++) begin
      wreg(`CMDT_OFF_START, 16'h0000);
      wreg(`CMDT_OFF_CNT, 16'h0000);
      wreg(`CMDT_OFF_COR, 16'h0001);
      wreg(`CMDT_OFF_CSR, 16'h0010 | 16'(s));
      wreg(`CMDT_OFF_START, 16'h0001);
      wait_dma(t0);
      wait_dma(t1);
      chk("interval", 16'(2 * div[s]), 16'(t1 - t0));
      rchk(`CMDT_OFF_CNT, 16'h0000, "counter");
    end
    $display("test dividers done");
  endtask : test_dividers
  task automatic test_flag;
    wreg(`CMDT_OFF_START, 16'h0000);
    wreg(`CMDT_OFF_CSR, 16'h0013);
    rchk(`CMDT_OFF_CSR, 16'h0093, "flag unarmed");
    wreg(`CMDT_OFF_CSR, 16'h0013);
    rchk(`CMDT_OFF_CSR, 16'h0013, "flag cleared");
    $display("test flag done");
  endtask : test_flag
  task automatic test_disabled;
    int n;
    n = 0;
    wreg(`CMDT_OFF_CSR, 16'h0000);
    // Open the mask so a match that reached irq would show
    wreg(`CMDT_OFF_IMSK, 16'h0003);
    wreg(`CMDT_OFF_START, 16'h0001);
    repeat (40) begin
      @(posedge clk);
      #1;
      if (dma_req !== 1'b0) n++;
      if (irq !== 1'b0) n++;
    end
    chk("quiet", 16'h0000, 16'(n));
    wreg(`CMDT_OFF_START, 16'h0000);
    wreg(`CMDT_OFF_IMSK, 16'h0000);
    rchk(`CMDT_OFF_CSR, 16'h0080, "flag set");
    $display("test disabled done");
  endtask : test_disabled
  // Counter and period writes while running are faults; a low period is a second one
  task automatic test_irq;
    wreg(`CMDT_OFF_START, 16'h0001);
    wreg(`CMDT_OFF_CNT, 16'h0100);
    wreg(`CMDT_OFF_COR, 16'h0010);
    rchk(`CMDT_OFF_IST, 16'h0003, "fault");
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wreg(`CMDT_OFF_IMSK, 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 16'h0001, {15'h0000, irq});
    wreg(`CMDT_OFF_IST, 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    rchk(`CMDT_OFF_IST, 16'h0002, "fault left");
    wreg(`CMDT_OFF_START, 16'h0000);
    $display("test irq done");
  endtask : test_irq
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    test_dividers();
    test_flag();
    test_disabled();
    test_irq();
    chk("requests", 16'(pulses), 16'(seen));
    end_of_test();
  end
  // Whole run takes about 540 cycles
  initial begin
    #(25 * 20000);
    errors++;
    end_of_test();
  end
endmodule : testbench
